/* File: trs_pkg.sv */
// Purpose: Constants shared by the timing reference selector
// Assumes: 50 MHz local oscillator clock
// Notes: Long times are kept in their own units, cycle counts derived
package trs_pkg;
    localparam int TRS_NREF = 4;
    localparam int TRS_CLK_HZ = 50000000;
    // Hold-off between switches, seconds
    localparam int TRS_HOLD_S = 10;
    localparam int TRS_HOLD_CYC = TRS_HOLD_S * TRS_CLK_HZ;
    // Loss of signal persistence, milliseconds
    localparam int TRS_LOS_MS = 100;
    localparam int TRS_LOS_CYC = TRS_LOS_MS * (TRS_CLK_HZ / 1000);
    // Error ratio persistence, milliseconds
    localparam int TRS_BER_MS = 2500;
    localparam int TRS_BER_CYC = TRS_BER_MS * (TRS_CLK_HZ / 1000);
    // Phase hit size, ns; count of 20 ns ticks
    localparam int TRS_HIT_NS = 1000;
    localparam int TRS_HIT_CYC = TRS_HIT_NS / 20;
    // Nominal line rate, hertz; pull-in tolerances, millihertz
    localparam int TRS_NOM_HZ = 1544000;
    localparam logic [2:0] TRS_GR_S2 = 3'h0;
    localparam logic [2:0] TRS_GR_S3 = 3'h1;
    localparam logic [2:0] TRS_GR_S4A = 3'h2;
    localparam logic [2:0] TRS_GR_S4B = 3'h3;
    localparam logic [31:0] TRS_PULL_S2_MHZ = 32'h32;     // 0.05 Hz
    localparam logic [31:0] TRS_PULL_S3_MHZ = 32'h3a98;   // 15 Hz
    localparam logic [31:0] TRS_PULL_S4_MHZ = 32'h186a0;  // 100 Hz
    localparam logic [31:0] TRS_PULL_WIDE_MHZ = 32'h30d40; // 200 Hz
    localparam int TRS_CW = 30;
    // Register byte offsets
    localparam logic [3:0] TRS_A_CTRL = 4'h0;
    localparam logic [3:0] TRS_A_PRIO = 4'h1;
    localparam logic [3:0] TRS_A_STAT = 4'h2;
    localparam logic [3:0] TRS_A_IRQ = 4'h3;
    localparam logic [3:0] TRS_A_MASK = 4'h4;
    localparam logic [3:0] TRS_A_FREQ = 4'h5;
    localparam logic [3:0] TRS_A_SLEW = 4'h6;
    // Interrupt bit positions
    localparam int TRS_IB_SW = 0;
    localparam int TRS_IB_FREE = 1;
    localparam int TRS_IB_FAIL = 2;
    typedef enum logic [2:0] {
        TRS_ST_FREE = 3'h1,
        TRS_ST_LOCK = 3'h2,
        TRS_ST_HOLD = 3'h4
    } trs_state_e;
endpackage : trs_pkg

/* File: trs_selector.sv */
// Purpose: Timing reference selector with hold-off and an output control word slew-limited in every grade but Type II
// Assumes: Reference clocks and alarm pins are asynchronous to clk
// Notes: Frequency steering is a control word for an external NCO
`timescale 1ns/1ps
`default_nettype none
module trs_selector
    import trs_pkg::*;
#(
    parameter int HOLD_CYC = trs_pkg::TRS_HOLD_CYC,
    parameter int LOS_CYC = trs_pkg::TRS_LOS_CYC,
    parameter int BER_CYC = trs_pkg::TRS_BER_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [trs_pkg::TRS_NREF-1:0] ref_clk,
    input wire logic [trs_pkg::TRS_NREF-1:0] ref_data,
    input wire logic [trs_pkg::TRS_NREF-1:0] ref_ber_alm,
    input wire logic [trs_pkg::TRS_NREF-1:0] ref_jit_alm,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [31:0] freq_word,
    output logic out_en,
    output logic irq
);
    import trs_pkg::*;

    localparam int N = TRS_NREF;
    localparam int PW = $clog2(N);

    // Two-flop synchronisers on every reference and alarm pin from outside
    logic [N-1:0] clk_s1_r, clk_s2_r, clk_s3_r;
    logic [N-1:0] dat_s1_r, dat_s2_r, ber_s1_r, ber_s2_r, jit_s1_r, jit_s2_r;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            {clk_s1_r, clk_s2_r, clk_s3_r} <= '0;
            {dat_s1_r, dat_s2_r, ber_s1_r, ber_s2_r, jit_s1_r, jit_s2_r} <= '0;
        end
        else if (ce)
        begin
            clk_s1_r <= ref_clk;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
            dat_s1_r <= ref_data;
            dat_s2_r <= dat_s1_r;
            ber_s1_r <= ref_ber_alm;
            ber_s2_r <= ber_s1_r;
            jit_s1_r <= ref_jit_alm;
            jit_s2_r <= jit_s1_r;
        end
    end

    // Edge of each reference, read only from the second flop onward
    wire [N-1:0] ref_edge = clk_s2_r & ~clk_s3_r;

    // Software registers
    logic [2:0] grade_r;
    logic wide_r, force_free_r;
    logic [N*PW-1:0] prio_r;
    logic [2:0] irq_r, mask_r;
    logic [31:0] slew_r;
    logic [N-1:0] fail;
    logic [PW-1:0] act_r;
    trs_state_e st_r;

    // Per reference failure detectors
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_det
            logic [31:0] los_cnt_r, ber_cnt_r, per_cnt_r, per_ref_r;
            logic los_r, ber_r, hit_r;
            wire [31:0] per_diff = (per_cnt_r > per_ref_r) ? per_cnt_r - per_ref_r : per_ref_r - per_cnt_r;
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    {los_cnt_r, ber_cnt_r, per_cnt_r, per_ref_r} <= '0;
                    {los_r, ber_r, hit_r} <= '0;
                end
                else if (ce)
                begin
                    // All zeros: no mark seen on data
                    los_cnt_r <= dat_s2_r[g] ? 32'h0 : los_cnt_r + 32'h1;
                    los_r <= (los_cnt_r >= 32'(LOS_CYC));
                    ber_cnt_r <= ber_s2_r[g] ? ber_cnt_r + 32'h1 : 32'h0;
                    ber_r <= (ber_cnt_r >= 32'(BER_CYC));
                    // Period step against last period flags a phase hit
                    per_cnt_r <= ref_edge[g] ? 32'h0 : per_cnt_r + 32'h1;
                    if (ref_edge[g])
                    begin
                        per_ref_r <= per_cnt_r;
                        hit_r <= (per_ref_r != 32'h0) && (per_diff >= 32'(TRS_HIT_CYC));
                    end
                end
            end
            assign fail[g] = los_r | ber_r | hit_r | jit_s2_r[g];
        end
    endgenerate

    // Best healthy reference in priority order
    logic [PW-1:0] best;
    logic best_ok;
    always_comb
    begin
        best = '0;
        best_ok = 1'b0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (!fail[prio_r[i*PW +: PW]])
            begin
                best = prio_r[i*PW +: PW];
                best_ok = 1'b1;
            end
        end
    end

    // Hold-off timer between switches
    logic [31:0] hold_cnt_r;
    wire hold_done = (hold_cnt_r == 32'h0);
    wire act_fail = fail[act_r];
    wire is_type2 = (grade_r == TRS_GR_S4B);
    wire want_sw = (st_r == TRS_ST_LOCK) && act_fail && best_ok && hold_done;
    wire want_free = (force_free_r || !best_ok) && (st_r == TRS_ST_LOCK);
    wire want_lock = (st_r != TRS_ST_LOCK) && !force_free_r && best_ok && hold_done;

    // Measured period of active reference, in clk cycles, used directly as the target word
    logic [31:0] mper_r, per_run_r;
    wire [31:0] tgt_word = mper_r;

    // Pull-in window by grade, in millihertz of offset
    wire [31:0] pull_lim = (grade_r == TRS_GR_S2) ? TRS_PULL_S2_MHZ :
                           (grade_r == TRS_GR_S3) ? TRS_PULL_S3_MHZ :
                           wide_r ? TRS_PULL_WIDE_MHZ : TRS_PULL_S4_MHZ;
    logic [31:0] off_r;
    wire in_pull = (off_r <= pull_lim);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= TRS_ST_FREE;
            act_r <= '0;
            hold_cnt_r <= '0;
        end
        else if (ce)
        begin
            if (!hold_done)
                hold_cnt_r <= hold_cnt_r - 32'h1;
            case (st_r)
                TRS_ST_LOCK:
                begin
                    if (want_free)
                        st_r <= (grade_r == TRS_GR_S2 || grade_r == TRS_GR_S3) ? TRS_ST_HOLD : TRS_ST_FREE;
                    else if (want_sw && best != act_r)
                    begin
                        act_r <= best;
                        hold_cnt_r <= 32'(HOLD_CYC);
                    end
                end
                TRS_ST_FREE, TRS_ST_HOLD:
                begin
                    if (want_lock)
                    begin
                        st_r <= TRS_ST_LOCK;
                        act_r <= best;
                        hold_cnt_r <= 32'(HOLD_CYC);
                    end
                end
                default: st_r <= TRS_ST_FREE;
            endcase
        end
    end

    // Period of active reference and offset estimate, used as steering
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mper_r <= '0;
            per_run_r <= '0;
            off_r <= '0;
        end
        else if (ce)
        begin
            per_run_r <= ref_edge[act_r] ? 32'h0 : per_run_r + 32'h1;
            if (ref_edge[act_r])
                mper_r <= per_run_r;
            off_r <= (freq_word > tgt_word) ? freq_word - tgt_word : tgt_word - freq_word;
        end
    end

    // Output word moves by at most the slew step per cycle, except in Type II where it jumps straight to the goal; no overshoot
    wire [31:0] goal = (st_r == TRS_ST_LOCK && in_pull) ? tgt_word :
                       (st_r == TRS_ST_HOLD) ? freq_word : 32'(TRS_NOM_HZ);
    wire [31:0] gap = (goal > freq_word) ? goal - freq_word : freq_word - goal;
    wire [31:0] step = (is_type2 || gap < slew_r) ? gap : slew_r;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            freq_word <= 32'(TRS_NOM_HZ);
        else if (ce)
            freq_word <= (goal > freq_word) ? freq_word + step : freq_word - step;
    end

    // Type II stops transmitting when loop timing is lost
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            out_en <= 1'b0;
        else if (ce)
            out_en <= !is_type2 || (st_r == TRS_ST_LOCK);
    end

    // Bus decode; a read waits one cycle so registered data stands at the accepting edge
    logic rd_pend_r;
    wire wr = avs_write && ce;
    wire rd_load = avs_read && ce && !rd_pend_r;
    wire [2:0] ev = {act_fail && st_r == TRS_ST_LOCK, want_free, want_sw && best != act_r};
    // Writes land at once; a frozen block stalls every request
    assign avs_waitrequest = !ce || (avs_read && !rd_pend_r);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            grade_r <= TRS_GR_S4A;
            {wide_r, force_free_r} <= '0;
            prio_r <= '0;
            mask_r <= '0;
            irq_r <= '0;
            slew_r <= 32'h1;
            avs_readdata <= '0;
            rd_pend_r <= 1'b0;
        end
        else if (ce)
        begin
            if (wr && avs_address == TRS_A_CTRL)
                {force_free_r, wide_r, grade_r} <= avs_writedata[4:0];
            if (wr && avs_address == TRS_A_PRIO)
                prio_r <= avs_writedata[N*PW-1:0];
            if (wr && avs_address == TRS_A_MASK)
                mask_r <= avs_writedata[2:0];
            if (wr && avs_address == TRS_A_SLEW)
                slew_r <= avs_writedata;
            // Set wins over a same-cycle clear
            irq_r <= (irq_r & ~((wr && avs_address == TRS_A_IRQ) ? avs_writedata[2:0] : 3'h0)) | ev;
            // Pending flag drops on the accepting edge, so a held read starts anew
            rd_pend_r <= rd_load;
            // Read data is captured once and then stands until the next read
            if (rd_load)
            begin
                case (avs_address)
                    TRS_A_CTRL: avs_readdata <= {27'h0, force_free_r, wide_r, grade_r};
                    TRS_A_PRIO: avs_readdata <= 32'(prio_r);
                    TRS_A_STAT: avs_readdata <= {16'h0, 4'(fail), 5'h0, st_r, 2'(act_r), 2'h0};
                    TRS_A_IRQ: avs_readdata <= {29'h0, irq_r};
                    TRS_A_MASK: avs_readdata <= {29'h0, mask_r};
                    TRS_A_FREQ: avs_readdata <= freq_word;
                    TRS_A_SLEW: avs_readdata <= slew_r;
                    default: avs_readdata <= 32'h0;
                endcase
            end
        end
    end
    assign irq = |(irq_r & mask_r);
endmodule : trs_selector
`default_nettype wire

/* File: trs_selector_properties.sv */
// Purpose: Port-level checks for the timing reference selector
// Assumes: One clk domain, nrst asynchronous and active low
// Notes: Grade and step limit are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module trs_selector_properties
    import trs_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [31:0] freq_word,
    input wire logic out_en,
    input wire logic irq
);
    logic [2:0] grade_r;
    logic [31:0] slew_r;
    wire logic take_w = ce && avs_write;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Shadow copies, so the step bound follows what software set
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            grade_r <= TRS_GR_S4A;
            slew_r <= 32'h1;
        end
        else if (take_w && avs_address == TRS_A_CTRL)
            grade_r <= avs_writedata[2:0];
        else if (take_w && avs_address == TRS_A_SLEW)
            slew_r <= avs_writedata;
    end
    a_wait_tracks_ce:
    assert property (!ce |-> avs_waitrequest) else $error("waitrequest low while frozen");
    a_read_wait:
    assert property (ce && avs_read && avs_waitrequest ##1 ce |-> !avs_waitrequest)
        else $error("read not answered after one wait");
    a_freeze_freq:
    assert property (!ce |=> $stable(freq_word)) else $error("freq word moved while frozen");
    a_freeze_outs:
    assert property (!ce |=> $stable(out_en) && $stable(irq)) else $error("outputs moved while frozen");
    a_rdata_stands:
    assert property (!(ce && avs_read && avs_waitrequest) |=> $stable(avs_readdata)) else $error("readdata moved");
    a_unmapped_zero:
    assert property (ce && avs_read && avs_waitrequest && avs_address > 4'h6 |=> avs_readdata == 32'h0)
        else $error("unmapped read");
    a_freq_readback:
    assert property (ce && avs_read && avs_waitrequest && avs_address == TRS_A_FREQ |=>
        avs_readdata == $past(freq_word)) else $error("frequency readback wrong");
    a_slew_bound:
    assert property (grade_r != TRS_GR_S4B && $past(grade_r) != TRS_GR_S4B |-> (freq_word > $past(freq_word) ?
        freq_word - $past(freq_word) : $past(freq_word) - freq_word) <= $past(slew_r))
        else $error("frequency step too big");
    a_slew_still:
    assert property ($past(slew_r) == 32'h0 && $past(grade_r) != TRS_GR_S4B |-> $stable(freq_word))
        else $error("zero step moved");
endmodule : trs_selector_properties
`default_nettype wire

/* File: trs_trunk_model.sv */
// Purpose: Trunk cards handing recovered references to the selector
// Assumes: 160 ns recovered clock, line data toggling while healthy
// Notes: Loss holds data low; a hit stretches periods by 1100 ns
`timescale 1ns/1ps
`default_nettype none
module trs_trunk_model
(
    output logic [3:0] ref_clk,
    output logic [3:0] ref_data,
    input wire logic [3:0] los,
    input wire logic [3:0] hit
);
    genvar g;
    // Offsets keep the cards out of phase, as real lines would be
    for (g = 0; g < 4; g++)
    begin : g_card
        logic c_r = 1'b0;
        logic d_r = 1'b0;
        assign ref_clk[g] = c_r;
        assign ref_data[g] = d_r;
        initial
        begin
            #(5 + 17 * g);
            forever
            begin
                #80 c_r = 1'b1;
                d_r = los[g] ? 1'b0 : ~d_r;
                #80 c_r = 1'b0;
                if (hit[g])
                    #1100;
            end
        end
    end
endmodule : trs_trunk_model
`default_nettype wire

/* File: trs_selector_tb.sv */
// Purpose: Self-checking bench for the timing reference selector
// Assumes: Hold-off 200, loss 50 and error 100 cycles
// Notes: Every wait for a status change is a bounded poll of the status word
`timescale 1ns/1ps
`default_nettype none
module trs_selector_tb;
    import trs_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] los = 4'h0, hit = 4'h0, ber = 4'h0, jit = 4'h4, addr = 4'h0, rclk, rdat;
    logic [31:0] wdata = 32'h0, rdata, freq, rv;
    logic waitreq, out_en, irq;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0;
    // Local oscillator and a cycle count for hold-off timing
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    trs_trunk_model u_trs_trunk_model (.ref_clk(rclk), .ref_data(rdat), .los(los), .hit(hit));
    trs_selector #(.HOLD_CYC(200), .LOS_CYC(50), .BER_CYC(100)) u_trs_selector (.clk(clk), .nrst(nrst), .ce(ce),
        .ref_clk(rclk), .ref_data(rdat), .ref_ber_alm(ber), .ref_jit_alm(jit), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq), .freq_word(freq),
        .out_en(out_en), .irq(irq));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // One bus cycle, held until waitrequest is sampled low; read data is taken at that same edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        while (waitreq !== 1'b0 && n < 100)
        begin
            n++;
            @(posedge clk);
        end
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 100)
        begin
            err_total++;
            give_verdict;
        end
        @(posedge clk);
    endtask : bus
    // Poll the status word until the masked field matches, within a bound
    task automatic wait_stat(input logic [31:0] m, input logic [31:0] v, input string name);
        int n;
        n = 0;
        bus(1'b0, TRS_A_STAT, 32'h0);
        while ((rv & m) !== v && n < 500)
        begin
            n++;
            bus(1'b0, TRS_A_STAT, 32'h0);
        end
        chk(name, rv & m, v);
        if (n == 500)
            give_verdict;
    endtask : wait_stat
    task automatic t_power_up;
        chk("freq at reset", freq, 32'h178f40);
        wait_stat(32'h7c, 32'h20, "locked to ref 0");
        bus(1'b1, 4'h7, 32'hffffffff);
        bus(1'b0, 4'h7, 32'h0);
        chk("unmapped read", rv, 32'h0);
        bus(1'b1, TRS_A_PRIO, 32'h000000d8);
        bus(1'b1, TRS_A_SLEW, 32'h4);
        bus(1'b1, TRS_A_MASK, 32'h1);
        bus(1'b1, TRS_A_IRQ, 32'h7);
        chk("irq cleared", irq, 1'b0);
    endtask : t_power_up
    // Loss on ref 0 moves the lock past jittery ref 2 to ref 1, not before the loss time
    task automatic t_switch;
        los[0] <= 1'b1;
        repeat (20) @(posedge clk);
        wait_stat(32'hc, 32'h0, "no switch before loss time");
        wait_stat(32'hc, 32'h4, "switch skips failed ref 2");
        t0 = cyc;
        chk("irq on switch", irq, 1'b1);
        wait_stat(32'h5000, 32'h5000, "loss and jitter flags");
        ber[1] <= 1'b1;
        repeat (130) @(posedge clk);
        wait_stat(32'h200c, 32'h2004, "error flag, still held off");
        wait_stat(32'hc, 32'hc, "switch to ref 3 after hold-off");
        chk("hold-off respected", cyc - t0 > 190, 1'b1);
    endtask : t_switch
    // A phase hit on ref 3 brings the lock back to the recovered ref 0
    task automatic t_hit;
        los[0] <= 1'b0;
        wait_stat(32'h1000, 32'h0, "ref 0 recovered");
        repeat (200) @(posedge clk);
        hit[3] <= 1'b1;
        repeat (100) @(posedge clk);
        hit[3] <= 1'b0;
        wait_stat(32'hc, 32'h0, "phase hit switches");
    endtask : t_hit
    // Every ref fails: free-run, then Type II gates its output
    task automatic t_free;
        los <= 4'h9;
        wait_stat(32'h70, 32'h10, "free-run when all fail");
        bus(1'b0, TRS_A_IRQ, 32'h0);
        chk("free-run event", rv & 32'h2, 32'h2);
        bus(1'b1, TRS_A_CTRL, 32'h3); // Only tried here as nothing downstream takes timing
        repeat (4) @(posedge clk);
        chk("type II output off", out_en, 1'b0);
        los <= 4'h0;
        ber <= 4'h0;
        jit <= 4'h0;
        wait_stat(32'h70, 32'h20, "type II relocks");
        repeat (4) @(posedge clk);
        chk("type II output on", out_en, 1'b1);
        // Forced free-run on a Stratum 2 grade goes to holdover, then relocks
        bus(1'b1, TRS_A_CTRL, 32'h10);
        wait_stat(32'h70, 32'h40, "forced holdover");
        bus(1'b1, TRS_A_CTRL, 32'h2);
        wait_stat(32'h70, 32'h20, "relock after force");
        ce <= 1'b0;
        repeat (8) @(posedge clk);
        ce <= 1'b1;
        bus(1'b0, TRS_A_FREQ, 32'h0);
        chk("freq after rearrangements", rv, 32'h178f40);
    endtask : t_free
    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_power_up;
        t_switch;
        t_hit;
        t_free;
        give_verdict;
    end
endmodule : trs_selector_tb
bind trs_selector trs_selector_properties u_trs_selector_properties (.clk(clk), .nrst(nrst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .freq_word(freq_word), .out_en(out_en),
    .irq(irq));
`default_nettype wire
